/* src/pdmi_defs.vh */
`ifndef PDMI_DEFS_VH
`define PDMI_DEFS_VH

// Register offsets on the plain register port.
`define PDMI_ADDR_CTRL       2'h0
`define PDMI_ADDR_DIV        2'h1
`define PDMI_ADDR_STATUS     2'h2

// Control register field positions.
`define PDMI_CTRL_JDF_LO     0
`define PDMI_CTRL_JDF_HI     1
`define PDMI_CTRL_MASTER_BIT 2
`define PDMI_CTRL_SRC_BIT    3
`define PDMI_CTRL_RAT_LO     4
`define PDMI_CTRL_RAT_HI     6

// Field values.
`define PDMI_JDF_MIC_DATA    2'h2
`define PDMI_JDF_RESET       2'h0
`define PDMI_MASTER_RESET    1'h0
`define PDMI_SRC_RESET       1'h0

// Bit clock to sample rate ratio codes.
`define PDMI_RAT_32          3'h0
`define PDMI_RAT_48          3'h1
`define PDMI_RAT_64          3'h2
`define PDMI_RAT_128         3'h3
`define PDMI_RAT_256         3'h4
`define PDMI_RAT_RESET       3'h2

// Timing: system clock rate and the bit clock range the microphones accept.
`define PDMI_CLK_HZ          10000000
`define PDMI_BCLK_MIN_HZ     1000000
`define PDMI_BCLK_MAX_HZ     3300000
// Shortest half period rounds up, longest rounds down.
`define PDMI_HALF_MIN_CYC    ((`PDMI_CLK_HZ + 2 * `PDMI_BCLK_MAX_HZ - 1) / (2 * `PDMI_BCLK_MAX_HZ))
`define PDMI_HALF_MAX_CYC    (`PDMI_CLK_HZ / (2 * `PDMI_BCLK_MIN_HZ))
`define PDMI_HALF_RESET      3'h2

`endif

/* src/pdmi_dual_mic_input.v */
// Overview of operation
// - Up to two microphones share one data line, read as separate left and right streams.
// - The codec makes the microphone bit clock and is master on that line.
// - Bit clock frequency is held between 1 MHz and 3.3 MHz.
// - Bit clock is 64 times sample rate after reset; 32, 48, 128, 256 selectable.
// - Jack pin function field at binary 10 makes the jack pin the mic data input.
// - Master select bit at 1 makes the port master and drive the bit clock.
// - Input source select at 1 takes mic inputs and disables the converter inputs.
// - One microphone works with the same clock and data wiring as two.
`include "pdmi_defs.vh"
`default_nettype none

module pdmi_dual_mic_input (
    input  wire       clk,
    input  wire       rst,
    input  wire [1:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    output reg        codec_bit_clock_pin_o,
    output reg        codec_bit_clock_pin_oe,
    input  wire       jack_detect_mic_data_pin_i,
    output reg        pdm_left_o,
    output reg        pdm_right_o,
    output reg        pdm_left_valid,
    output reg        pdm_right_valid,
    output reg        sample_tick,
    output reg        adc_input_enable
);

    localparam integer HALF_MIN_I = `PDMI_HALF_MIN_CYC;
    localparam integer HALF_MAX_I = `PDMI_HALF_MAX_CYC;
    localparam [2:0]   HALF_MIN   = HALF_MIN_I[2:0];
    localparam [2:0]   HALF_MAX   = HALF_MAX_I[2:0];

    reg [1:0] jack_pin_function_select_r;
    reg       port_master_select_r;
    reg       input_source_select_r;
    reg [2:0] ratio_sel_r;
    reg [2:0] half_r;
    reg [2:0] half_cnt_r;
    reg [8:0] bit_cnt_r;
    reg       bclk_r;
    reg       din_meta_r;
    reg       din_sync_r;
    reg       pin_d_r;
    reg [8:0] frame_last;
    reg [2:0] half_nxt;
    wire      mic_path_on;
    wire      half_done;

    // Frame length in bit clocks minus one for the selected ratio.
    always @*
    begin
        case (ratio_sel_r)
            `PDMI_RAT_32:  frame_last = 9'h01F;
            `PDMI_RAT_48:  frame_last = 9'h02F;
            `PDMI_RAT_128: frame_last = 9'h07F;
            `PDMI_RAT_256: frame_last = 9'h0FF;
            default:       frame_last = 9'h03F;
        endcase
    end

    // Written half periods are clamped into the range the microphones accept.
    always @*
    begin
        if (reg_wdata[2:0] < HALF_MIN)
            half_nxt = HALF_MIN;
        else if (reg_wdata[2:0] > HALF_MAX)
            half_nxt = HALF_MAX;
        else
            half_nxt = reg_wdata[2:0];
    end

    assign mic_path_on = (jack_pin_function_select_r == `PDMI_JDF_MIC_DATA)
                         && input_source_select_r && port_master_select_r;
    assign half_done   = (half_cnt_r == half_r - 3'h1);

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            jack_pin_function_select_r <= `PDMI_JDF_RESET;
            port_master_select_r       <= `PDMI_MASTER_RESET;
            input_source_select_r      <= `PDMI_SRC_RESET;
            ratio_sel_r                <= `PDMI_RAT_RESET;
            half_r                     <= `PDMI_HALF_RESET;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `PDMI_ADDR_CTRL)
            begin
                jack_pin_function_select_r <= reg_wdata[`PDMI_CTRL_JDF_HI:`PDMI_CTRL_JDF_LO];
                port_master_select_r       <= reg_wdata[`PDMI_CTRL_MASTER_BIT];
                input_source_select_r      <= reg_wdata[`PDMI_CTRL_SRC_BIT];
                ratio_sel_r                <= reg_wdata[`PDMI_CTRL_RAT_HI:`PDMI_CTRL_RAT_LO];
            end
            if (reg_addr == `PDMI_ADDR_DIV)
                half_r <= half_nxt;
        end
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                `PDMI_ADDR_CTRL:   reg_rdata <= {1'b0, ratio_sel_r, input_source_select_r,
                                                 port_master_select_r, jack_pin_function_select_r};
                `PDMI_ADDR_DIV:    reg_rdata <= {5'h00, half_r};
                `PDMI_ADDR_STATUS: reg_rdata <= {4'h0, mic_path_on, pdm_right_o, pdm_left_o,
                                                 codec_bit_clock_pin_oe};
                default:           reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end

    // Two-flop synchroniser for the shared data line.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            din_meta_r <= 1'b0;
            din_sync_r <= 1'b0;
        end
        else
        begin
            din_meta_r <= jack_detect_mic_data_pin_i;
            din_sync_r <= din_meta_r;
        end
    end

    // Bit clock generator; the clock runs only while the port is master.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            half_cnt_r <= 3'h0;
            bclk_r     <= 1'b0;
            bit_cnt_r  <= 9'h000;
        end
        else if (!port_master_select_r)
        begin
            half_cnt_r <= 3'h0;
            bclk_r     <= 1'b0;
            bit_cnt_r  <= 9'h000;
        end
        else if (half_done)
        begin
            half_cnt_r <= 3'h0;
            bclk_r     <= ~bclk_r;
            if (bclk_r)
                bit_cnt_r <= (bit_cnt_r >= frame_last) ? 9'h000 : bit_cnt_r + 9'h001;
        end
        else
            half_cnt_r <= half_cnt_r + 3'h1;
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            codec_bit_clock_pin_o  <= 1'b0;
            codec_bit_clock_pin_oe <= 1'b0;
            pin_d_r                <= 1'b0;
            pdm_left_o             <= 1'b0;
            pdm_right_o            <= 1'b0;
            pdm_left_valid         <= 1'b0;
            pdm_right_valid        <= 1'b0;
            sample_tick            <= 1'b0;
            adc_input_enable       <= 1'b1;
        end
        else
        begin
            // Gating with the master bit keeps the pin low from the cycle the output enable drops.
            codec_bit_clock_pin_o  <= bclk_r && port_master_select_r;
            pin_d_r                <= codec_bit_clock_pin_o;
            codec_bit_clock_pin_oe <= port_master_select_r;
            adc_input_enable       <= ~input_source_select_r;
            pdm_left_valid         <= 1'b0;
            pdm_right_valid        <= 1'b0;
            sample_tick            <= 1'b0;
            // The microphones change data right after each pin edge, and the line needs two
            // cycles through the synchroniser. One cycle after a pin edge is seen, the
            // synchroniser still holds the slot that the edge has just closed.
            // This costs two cycles of latency but is safe at the shortest half period.
            if (mic_path_on && codec_bit_clock_pin_o && !pin_d_r)
            begin
                pdm_left_o     <= din_sync_r;
                pdm_left_valid <= 1'b1;
                sample_tick    <= (bit_cnt_r == 9'h000);
            end
            if (mic_path_on && !codec_bit_clock_pin_o && pin_d_r)
            begin
                pdm_right_o     <= din_sync_r;
                pdm_right_valid <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

/* testbench/pdmi_mic_model.sv */
`default_nettype none
module pdmi_mic_model (
    input  wire logic bclk,
    input  wire logic l_on,
    input  wire logic r_on,
    input  wire logic l_bit,
    input  wire logic r_bit,
    output var  logic data,
    output var  logic l_sent,
    output var  logic r_sent
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        data = 1'b0;
        l_sent = 1'b0;
        r_sent = 1'b0;
    end
    // The left device drives the low half, the right one the high half.
    // An empty slot carries the inverse of the last bit.
    always @(negedge bclk)
    begin
        data = l_on ? l_bit : ~data;
        l_sent = data;
    end
    always @(posedge bclk)
    begin
        data = r_on ? r_bit : ~data;
        r_sent = data;
    end
endmodule
`default_nettype wire

/* testbench/pdmi_dual_mic_input_asserts.sv */
`default_nettype none
module pdmi_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic codec_bit_clock_pin_o,
    input wire logic codec_bit_clock_pin_oe,
    input wire logic pdm_left_valid,
    input wire logic pdm_right_valid,
    input wire logic sample_tick
);
    timeunit 1ns;
    timeprecision 1ns;
    wire b = codec_bit_clock_pin_o;
    wire oe = codec_bit_clock_pin_oe;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_rise; $rose(b); endsequence
    sequence s_fall; $fell(b); endsequence
    sequence s_rose_seen; b && $past(b) && !$past(b, 2); endsequence
    sequence s_fell_seen; !b && !$past(b) && $past(b, 2); endsequence
    property p_idle; !oe |-> !b; endproperty
    a_idle: assert property (p_idle) else $error("clock moves while released");
    property p_hmin; s_rise |=> b || !oe; endproperty
    a_hmin: assert property (p_hmin) else $error("half period too short");
    property p_hmax; oe && $changed(b) |-> ##[1:5] ($changed(b) || !oe); endproperty
    a_hmax: assert property (p_hmax) else $error("half period too long");
    property p_lv; pdm_left_valid |-> s_rose_seen; endproperty
    a_lv: assert property (p_lv) else $error("left bit off the rising edge");
    property p_rv; pdm_right_valid |-> s_fell_seen; endproperty
    a_rv: assert property (p_rv) else $error("right bit off the falling edge");
    property p_voe; pdm_left_valid || pdm_right_valid |-> oe; endproperty
    a_voe: assert property (p_voe) else $error("data without clock");
    property p_tick; sample_tick |-> pdm_left_valid; endproperty
    a_tick: assert property (p_tick) else $error("tick without left bit");
    property p_alt; pdm_left_valid |=> !pdm_left_valid [*3]; endproperty
    a_alt: assert property (p_alt) else $error("left bits too close");
endmodule
bind pdmi_dual_mic_input pdmi_chk i_chk (.*);
`default_nettype wire

/* testbench/tb.sv */
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, l_on = 1'b1, r_on = 1'b1;
    logic       l_bit = 1'b0, r_bit = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, cv [3] = '{8'h2D, 8'h26, 8'h2A};
    logic       codec_bit_clock_pin_o, codec_bit_clock_pin_oe, pdm_left_o, pdm_right_o;
    logic       pdm_left_valid, pdm_right_valid, sample_tick, adc_input_enable;
    wire        jack_detect_mic_data_pin_i, ls, rs;
    wire        bclk = codec_bit_clock_pin_oe & codec_bit_clock_pin_o;
    integer     seed = 2, err_count = 0, check_count = 0, n, i, v;
    pdmi_dual_mic_input i_dut (.*);
    pdmi_mic_model i_mic (.bclk(bclk), .l_on(l_on), .r_on(r_on), .l_bit(l_bit), .r_bit(r_bit),
        .data(jack_detect_mic_data_pin_i), .l_sent(ls), .r_sent(rs));
    always #50 clk = ~clk;
    always @(posedge clk)
    begin
        {l_bit, r_bit} <= 2'($random(seed));
        if (pdm_left_valid) `CHK(pdm_left_o, ls)
        if (pdm_right_valid && r_on) `CHK(pdm_right_o, rs)
    end
    function automatic integer ratio(input integer c);
        ratio = c == 0 ? 32 : c == 1 ? 48 : c == 3 ? 128 : c == 4 ? 256 : 64;
    endfunction
    task automatic end_of_test;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask
    task automatic tk;
        n = 1;
        @(negedge clk);
        while (sample_tick !== 1'b1 && n < 5000)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 5000)
        begin
            err_count++;
            end_of_test;
        end
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        `CHK(codec_bit_clock_pin_oe, 1'b0)
        `CHK(adc_input_enable, 1'b1)
        rd(2'h0, 8'h20);
        rd(2'h3, 8'h00);
        for (i = 0; i < 6; i++)
        begin
            v = i < 2 ? i * 7 : $unsigned($random(seed)) % 8;
            wr(2'h1, v[7:0]);
            rd(2'h1, v < 2 ? 8'h02 : v > 5 ? 8'h05 : v[7:0]);
        end
        $display("test divider done");
        wr(2'h1, 8'h04);
        for (i = 0; i < 6; i++)
        begin
            wr(2'h0, {1'b0, i[2:0], 4'hE});
            tk;
            tk;
            `CHK(n, ratio(i) * 8)
            `CHK(adc_input_enable, 1'b0)
        end
        $display("test ratio done");
        for (i = 0; i < 3; i++)
        begin
            wr(2'h0, cv[i]);
            repeat (2) @(posedge clk);
            n = 0;
            repeat (200) @(posedge clk) n += pdm_left_valid + pdm_right_valid;
            `CHK(n, 0)
            `CHK(codec_bit_clock_pin_oe, cv[i][2])
        end
        $display("test gating done");
        r_on <= 1'b0;
        v = 4 + $unsigned($random(seed)) % 2;
        wr(2'h1, v[7:0]);
        wr(2'h0, 8'h2E);
        rd(2'h0, 8'h2E);
        tk;
        tk;
        `CHK(n, 128 * v)
        $display("test mono done");
        end_of_test;
    end
endmodule
`default_nettype wire
